/* nvs_acc_if.sv */
`timescale 1ns/100ps
interface nvs_acc_if;
    logic                    req;
    logic                    we;
    logic                    last;
    logic [nvs_pkg::AW-1:0]  addr;
    logic [nvs_pkg::DW-1:0]  wdata;
    logic                    ack;
    logic [nvs_pkg::DW-1:0]  rdata;

    modport seq (input req, we, last, addr, wdata, output ack, rdata);
    modport ctl (output req, we, last, addr, wdata, input ack, rdata);
endinterface : nvs_acc_if

/* nvs_host_ctrl.sv */
// Operation
// RULE1: write strobe high on reads, low writes
// RULE2: write strobe low at select keeps outputs off
// RULE3: six key reads start save or copy back
// RULE4: key addresses consecutive and in exact order
// RULE5: write strobe high through all key reads
// RULE6: power-up copy done within 550 us
// RULE7: read or write decoded from control pins
// RULE8: intervening access aborts the key sequence
// RULE9: save ignores all access for 10 ms
// RULE10: copy back finished within 20 us
// RULE11: device key detector steps per read
`timescale 1ns/100ps
module nvs_host_ctrl #(
    parameter int PWRUP_CYC = nvs_pkg::PWRUP_COPY_CYC,
    parameter int SAVE_CYC  = nvs_pkg::SAVE_CYC,
    parameter int STROBE    = nvs_pkg::STROBE_CYC
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // command port
    input  wire logic                   cmd_valid,
    output logic                        cmd_ready,
    input  wire logic [1:0]             cmd_op,
    input  wire logic [nvs_pkg::AW-1:0] cmd_addr,
    input  wire logic [nvs_pkg::DW-1:0] cmd_wdata,
    // answer and status
    output logic                        rsp_valid,
    output logic [nvs_pkg::DW-1:0]      rsp_rdata,
    output logic                        busy,
    // memory pins
    output logic                        ce_n,
    output logic                        we_n,
    output logic                        oe_n,
    output logic [nvs_pkg::AW-1:0]      addr_in,
    output logic [nvs_pkg::DW-1:0]      data_io_o,
    output logic                        data_io_oe_n,
    input  wire logic [nvs_pkg::DW-1:0] data_io_i
);
    // loads are one less than the count: zero is the last waited cycle
    localparam logic [nvs_pkg::TW-1:0] PWRUP_LOAD =
        nvs_pkg::TW'(PWRUP_CYC - 1);
    localparam logic [nvs_pkg::TW-1:0] SAVE_LOAD =
        nvs_pkg::TW'(SAVE_CYC - 1);
    localparam logic [nvs_pkg::TW-1:0] COPY_LOAD =
        nvs_pkg::TW'(nvs_pkg::COPY_BACK_CYC - 1);

    typedef enum logic [4:0] {
        HC_PWRUP = 5'h01,
        HC_IDLE  = 5'h02,
        HC_ACC   = 5'h04,
        HC_KEY   = 5'h08,
        HC_WAIT  = 5'h10
    } nvs_hc_e;

    typedef struct packed {
        nvs_hc_e                st;
        logic                   save;
        logic [2:0]             step;
        logic [nvs_pkg::TW-1:0] tmr;
        logic                   req;
        logic                   we;
        logic                   last;
        logic [nvs_pkg::AW-1:0] addr;
        logic [nvs_pkg::DW-1:0] wdata;
        logic                   rsp;
        logic [nvs_pkg::DW-1:0] rdata;
    } nvs_hc_s;

    nvs_hc_s q, d;
    nvs_acc_if acc ();

    // both timed waits share one down counter
    function automatic logic [nvs_pkg::TW-1:0] tmr_dec(
        input logic [nvs_pkg::TW-1:0] t
    );
        return t - nvs_pkg::TW'(1);
    endfunction : tmr_dec

    function automatic logic tmr_zero(
        input logic [nvs_pkg::TW-1:0] t
    );
        return t == '0;
    endfunction : tmr_zero

    // full command codes compared here; key commands picked out by cmd_op[1]
    function automatic logic op_is(
        input logic [1:0]       op,
        input nvs_pkg::nvs_op_e code
    );
        return op == 2'(code);
    endfunction : op_is

    // queue one pin access; the sequencer takes it from idle
    function automatic nvs_hc_s acc_start(
        input nvs_hc_s                s,
        input logic                   we,
        input logic                   last,
        input logic [nvs_pkg::AW-1:0] addr
    );
        nvs_hc_s r;
        r = s;
        r.req = 1'b1;
        r.we = we;
        r.last = last;
        r.addr = addr;
        return r;
    endfunction : acc_start

    nvs_pin_seq #(
        .STROBE       (STROBE)
    ) u_seq (
        .mclk         (mclk),
        .rst_n        (rst_n),
        .acc          (acc.seq),
        .ce_n         (ce_n),
        .we_n         (we_n),
        .oe_n         (oe_n),
        .addr_in      (addr_in),
        .data_io_o    (data_io_o),
        .data_io_oe_n (data_io_oe_n),
        .data_io_i    (data_io_i)
    );

    always_comb begin
        d = q;
        d.rsp = 1'b0;
        case (q.st)
            HC_PWRUP: begin
                // RULE6 wait power-up copy
                // pins stay deselected so no write lands in the copy
                if (tmr_zero(q.tmr)) begin
                    d.st = HC_IDLE;
                end else begin
                    d.tmr = tmr_dec(q.tmr);
                end
            end

            HC_IDLE: begin
                if (cmd_valid) begin
                    d.wdata = cmd_wdata;
                    if (cmd_op[1]) begin
                        // RULE3 start key sequence
                        d = acc_start(d, 1'b0, 1'b0,
                                      nvs_pkg::nvs_key_addr(3'h0, 1'b0));
                        d.st = HC_KEY;
                        d.save = op_is(cmd_op, nvs_pkg::NVS_OP_SAVE);
                        d.step = '0;
                    end else begin
                        // RULE7 plain access
                        d = acc_start(d,
                                      op_is(cmd_op, nvs_pkg::NVS_OP_WRITE),
                                      1'b0, cmd_addr);
                        d.st = HC_ACC;
                    end
                end
            end

            HC_ACC: begin
                if (acc.ack) begin
                    d.req = 1'b0;
                    d.st = HC_IDLE;
                    d.rsp = 1'b1;
                    // a write leaves the last read data standing
                    d.rdata = q.we ? q.rdata : acc.rdata;
                end
            end

            HC_KEY: begin
                // RULE4 RULE8 no other access until done
                if (acc.ack) begin
                    d.req = 1'b0;
                    if (q.step == nvs_pkg::KEY_LAST) begin
                        // RULE9 RULE10 hold off for the operation
                        d.st = HC_WAIT;
                        d.tmr = q.save ? SAVE_LOAD : COPY_LOAD;
                    end else begin
                        // RULE5 key reads never write
                        d.step = q.step + 3'h1;
                        d = acc_start(d, 1'b0,
                                      d.step == nvs_pkg::KEY_LAST,
                                      nvs_pkg::nvs_key_addr(d.step, q.save));
                    end
                end
            end

            HC_WAIT: begin
                if (tmr_zero(q.tmr)) begin
                    // rsp marks the end of the nonvolatile operation
                    d.st = HC_IDLE;
                    d.rsp = 1'b1;
                end else begin
                    d.tmr = tmr_dec(q.tmr);
                end
            end

            default: d.st = HC_IDLE;
        endcase
    end

    // power-up wait starts from reset, standing in for the supply rise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: HC_PWRUP, tmr: PWRUP_LOAD, default: '0};
        end else begin
            q <= d;
        end
    end

    assign acc.req = q.req;
    assign acc.we = q.we;
    assign acc.last = q.last;
    assign acc.addr = q.addr;
    assign acc.wdata = q.wdata;

    // accepting only in idle keeps key reads back to back
    assign cmd_ready = (q.st == HC_IDLE);
    assign busy = (q.st != HC_IDLE);
    assign rsp_valid = q.rsp;
    assign rsp_rdata = q.rdata;
endmodule : nvs_host_ctrl

/* nvs_host_properties.sv */
`timescale 1ns/100ps
module nvs_host_properties (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // command port
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [1:0]  cmd_op,
    input wire logic        rsp_valid,
    // memory pins
    input wire logic        ce_n,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic [12:0] addr_in,
    input wire logic        data_io_oe_n
);
    localparam logic [12:0] KEYS [5] =
        '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic        key_q, save_q, ce_q, take;
    logic [2:0]  step_q;
    logic [12:0] exp_a;
    assign take = cmd_valid && cmd_ready;
    assign exp_a = step_q < 3'h5 ? KEYS[step_q] :
                   save_q ? 13'h0F0F : 13'h0F0E;
    // step counts completed selects of one key operation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            key_q  <= 1'b0;
            save_q <= 1'b0;
            step_q <= 3'h0;
            ce_q   <= 1'b1;
        end else begin
            ce_q <= ce_n;
            if (take && cmd_op[1]) begin
                key_q  <= 1'b1;
                save_q <= !cmd_op[0];
                step_q <= 3'h0;
            end else if (rsp_valid) begin
                key_q <= 1'b0;
            end
            if (key_q && ce_n && !ce_q) begin
                step_q <= step_q + 3'h1;
            end
        end
    end
    rd_we_high_a: assert property (
        (!ce_n && !oe_n) |-> we_n) else $error("strobe low in read");
    wr_bus_drv_a: assert property (
        !we_n |-> (oe_n && !data_io_oe_n && !ce_n))
        else $error("write without bus drive");
    key_we_high_a: assert property (
        key_q |-> we_n) else $error("strobe low in key op");
    key_order_a: assert property (
        (key_q && $fell(ce_n)) |-> addr_in == exp_a)
        else $error("key address out of order");
    key_hiz_a: assert property (
        (key_q && step_q == 3'h5) |-> oe_n)
        else $error("sixth key read gates output on");
    key_count_a: assert property (
        (key_q && rsp_valid) |-> step_q == 3'h6)
        else $error("key op not six reads");
    addr_hold_a: assert property (
        (!ce_n && !ce_q) |-> $stable(addr_in))
        else $error("address moved under select");
    wr_time_a: assert property (
        (take && cmd_op == 2'h1) |-> ##[7:8] rsp_valid)
        else $error("write answer late");
    save_c: cover property (take && cmd_op == 2'h2);
    copy_c: cover property (take && cmd_op == 2'h3);
    write_c: cover property (take && cmd_op == 2'h1);
endmodule : nvs_host_properties

/* nvs_mem_model.sv */
`timescale 1ns/100ps
module nvs_mem_model #(
    parameter int SAVE_NS = 500,
    parameter int COPY_NS = 400
) (
    // memory pins
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic [12:0] addr_in,
    input  wire logic [7:0]  data_io_o,
    input  wire logic        data_io_oe_n,
    output logic [7:0]       data_io_i,
    // operation counts
    output int               save_cnt,
    output int               copy_cnt
);
    localparam logic [12:0] KEYS [5] =
        '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
    logic [7:0] mem [8192];
    logic [7:0] nv [8192];
    logic [7:0] last, wd;
    logic       wr, sel_wr, nv_busy, hiz6, drv;
    logic [2:0] step;
    assign hiz6 = step == 3'h5 && addr_in[12:1] == 12'h787;
    assign drv = !ce_n && !oe_n && we_n && !sel_wr && !nv_busy && !hiz6;
    // released bus shows the inverse, never a stale match
    assign data_io_i = !data_io_oe_n ? data_io_o :
                       drv ? mem[addr_in] : ~last;
    always @(negedge drv) last = mem[addr_in];
    always @(negedge ce_n) sel_wr = !we_n;
    always @* if (!ce_n && !we_n) begin
        wr = 1'b1;
        wd = data_io_o;
    end
    initial begin
        nv_busy = 1'b1;
        step = 3'h0;
        wr = 1'b0;
        sel_wr = 1'b0;
        last = 8'h00;
        save_cnt = 0;
        copy_cnt = 0;
        for (int i = 0; i < 8192; i++) begin
            nv[i] = 8'h00;
            mem[i] = nv[i];
        end
        #300;
        nv_busy = 1'b0;
    end
    always @(posedge ce_n) begin
        if (!nv_busy) begin
            if (wr) begin
                mem[addr_in] = wd;
                step = 3'h0;
            end else if (hiz6) begin
                nv_busy = 1'b1;
                step = 3'h0;
                if (addr_in[0]) begin
                    for (int i = 0; i < 8192; i++) nv[i] = mem[i];
                    save_cnt++;
                    #SAVE_NS;
                end else begin
                    for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
                    for (int i = 0; i < 8192; i++) mem[i] = nv[i];
                    copy_cnt++;
                    #COPY_NS;
                end
                nv_busy = 1'b0;
            end else begin
                step = (step < 3'h5 && addr_in == KEYS[step]) ?
                       step + 3'h1 : 3'h0;
            end
        end
        wr = 1'b0;
    end
endmodule : nvs_mem_model

/* nvs_pin_seq.sv */
`timescale 1ns/100ps
module nvs_pin_seq #(
    parameter int STROBE = nvs_pkg::STROBE_CYC
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // access requests
    nvs_acc_if.seq                      acc,
    // memory pins
    output logic                        ce_n,
    output logic                        we_n,
    output logic                        oe_n,
    output logic [nvs_pkg::AW-1:0]      addr_in,
    output logic [nvs_pkg::DW-1:0]      data_io_o,
    output logic                        data_io_oe_n,
    input  wire logic [nvs_pkg::DW-1:0] data_io_i
);
    typedef enum logic [3:0] {
        SQ_IDLE   = 4'h1,
        SQ_SETUP  = 4'h2,
        SQ_STROBE = 4'h4,
        SQ_DONE   = 4'h8
    } nvs_sq_e;

    typedef struct packed {
        nvs_sq_e                st;
        logic [7:0]             cnt;
        logic                   we;
        logic                   ce_n;
        logic                   we_n;
        logic                   oe_n;
        logic [nvs_pkg::AW-1:0] addr;
        logic [nvs_pkg::DW-1:0] dout;
        logic                   doe_n;
        logic [nvs_pkg::DW-1:0] rdata;
        logic                   ack;
        logic [nvs_pkg::DW-1:0] s1;
        logic [nvs_pkg::DW-1:0] s2;
        logic [nvs_pkg::DW-1:0] s3;
    } nvs_sq_s;

    nvs_sq_s q, d;

    always_comb begin
        d = q;
        d.s1 = data_io_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.ack = 1'b0;
        case (q.st)
            SQ_IDLE: begin
                if (acc.req) begin
                    d.st = SQ_SETUP;
                    d.we = acc.we;
                    d.addr = acc.addr;
                    d.dout = acc.wdata;
                    d.doe_n = ~acc.we;
                    // output gate stays high on writes and on the last key read
                    d.oe_n = acc.we | acc.last;
                end
            end
            SQ_SETUP: begin
                // RULE1 strobe per kind
                d.st = SQ_STROBE;
                d.ce_n = 1'b0;
                d.we_n = ~q.we;
                d.cnt = 8'(STROBE - 1);
            end
            SQ_STROBE: begin
                if (q.cnt != 8'h00) begin
                    d.cnt = q.cnt - 8'h01;
                end else if (q.we || q.s2 == q.s3) begin
                    // read data counted only once two sync stages agree
                    d.st = SQ_DONE;
                    d.ce_n = 1'b1;
                    d.we_n = 1'b1;
                    d.oe_n = 1'b1;
                    d.ack = 1'b1;
                    if (!q.we) begin
                        d.rdata = q.s3;
                    end
                end
            end
            SQ_DONE: begin
                // one cycle deselected, bus released after the write ended
                d.st = SQ_IDLE;
                d.doe_n = 1'b1;
            end
            default: d.st = SQ_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: SQ_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                   doe_n: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    assign ce_n = q.ce_n;
    assign we_n = q.we_n;
    assign oe_n = q.oe_n;
    assign addr_in = q.addr;
    assign data_io_o = q.dout;
    assign data_io_oe_n = q.doe_n;
    assign acc.ack = q.ack;
    assign acc.rdata = q.rdata;
endmodule : nvs_pin_seq

/* nvs_pkg.sv */
package nvs_pkg;
    // pin widths of the memory
    localparam int AW = 13;
    localparam int DW = 8;
    // clock rate used to turn times into cycle counts
    localparam int CLK_MHZ = 50;
    // automatic power-up copy, microseconds
    localparam int PWRUP_COPY_US = 550;
    localparam int PWRUP_COPY_CYC = PWRUP_COPY_US * CLK_MHZ;
    // save to the nonvolatile array, milliseconds
    localparam int SAVE_MS = 10;
    localparam int SAVE_CYC = SAVE_MS * 1000 * CLK_MHZ;
    // software copy back, microseconds
    localparam int COPY_BACK_US = 20;
    localparam int COPY_BACK_CYC = COPY_BACK_US * CLK_MHZ;
    // timer width, wide enough for the save count
    localparam int TW = 20;
    // default cycles of chip select low on one access
    localparam int STROBE_CYC = 3;
    // index of the last key step; the key sequence is six reads
    localparam logic [2:0] KEY_LAST = 3'h5;
    // key addresses
    localparam logic [AW-1:0] KEY_A0 = 13'h0000;
    localparam logic [AW-1:0] KEY_A1 = 13'h1555;
    localparam logic [AW-1:0] KEY_A2 = 13'h0AAA;
    localparam logic [AW-1:0] KEY_A3 = 13'h1FFF;
    localparam logic [AW-1:0] KEY_A4 = 13'h10F0;
    localparam logic [AW-1:0] KEY_SAVE = 13'h0F0F;
    localparam logic [AW-1:0] KEY_COPY = 13'h0F0E;

    // user commands
    typedef enum logic [1:0] {
        NVS_OP_READ  = 2'h0,
        NVS_OP_WRITE = 2'h1,
        NVS_OP_SAVE  = 2'h2,
        NVS_OP_COPY  = 2'h3
    } nvs_op_e;

    function automatic logic [AW-1:0] nvs_key_addr(
        input logic [2:0] step,
        input logic       is_save
    );
        logic [AW-1:0] a;
        case (step)
            3'h0: a = KEY_A0;
            3'h1: a = KEY_A1;
            3'h2: a = KEY_A2;
            3'h3: a = KEY_A3;
            3'h4: a = KEY_A4;
            default: a = is_save ? KEY_SAVE : KEY_COPY;
        endcase
        return a;
    endfunction : nvs_key_addr
endpackage : nvs_pkg

/* nvs_tb.sv */
`timescale 1ns/100ps
module testbench;
    localparam int PW = 20;
    logic        mclk, rst_n, cmd_valid, cmd_ready, rsp_valid, busy;
    logic        ce_n, we_n, oe_n, data_io_oe_n;
    logic [1:0]  cmd_op;
    logic [12:0] cmd_addr, addr_in;
    logic [7:0]  cmd_wdata, rsp_rdata, data_io_o, data_io_i;
    int          error_cnt, samples_checked, cyc, save_cnt, copy_cnt;

    nvs_host_ctrl #(.PWRUP_CYC(PW), .SAVE_CYC(30), .STROBE(3)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .busy(busy), .ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .addr_in(addr_in), .data_io_o(data_io_o),
        .data_io_oe_n(data_io_oe_n), .data_io_i(data_io_i));
    nvs_mem_model mem_u (
        .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr_in(addr_in),
        .data_io_o(data_io_o), .data_io_oe_n(data_io_oe_n),
        .data_io_i(data_io_i), .save_cnt(save_cnt), .copy_cnt(copy_cnt));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // a hang anywhere ends the run as a failure
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            summarize();
        end
    end
    task automatic cmp(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask : cmp
    task automatic cmd(input logic [1:0] op, input logic [12:0] a,
                       input logic [7:0] d);
        @(negedge mclk);
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge mclk);
    endtask : cmd
    task automatic t_powerup();
        int n;
        n = 0;
        cmp("busy in wait", 8'h01, 8'(busy));
        while (cmd_ready !== 1'b1) begin
            @(negedge mclk);
            n++;
        end
        cmp("powerup wait", 8'(PW), 8'(n));
        cmp("busy after wait", 8'h00, 8'(busy));
        $display("test powerup done");
    endtask : t_powerup
    task automatic t_rw();
        cmd(2'h1, 13'h1FFF, 8'hA5);
        cmd(2'h1, 13'h0000, 8'h3C);
        cmd(2'h0, 13'h1FFF, 8'h00);
        cmp("read top", 8'hA5, rsp_rdata);
        cmd(2'h0, 13'h0000, 8'h00);
        cmp("read base", 8'h3C, rsp_rdata);
        $display("test rw done");
    endtask : t_rw
    task automatic t_nv();
        cmd(2'h1, 13'h0123, 8'h5A);
        cmd(2'h2, 13'h0000, 8'h00);
        cmp("saves", 8'h01, 8'(save_cnt));
        cmd(2'h1, 13'h0123, 8'hC3);
        cmd(2'h0, 13'h0123, 8'h00);
        cmp("after save", 8'hC3, rsp_rdata);
        cmd(2'h3, 13'h0000, 8'h00);
        cmp("copies", 8'h01, 8'(copy_cnt));
        cmp("saves kept", 8'h01, 8'(save_cnt));
        cmd(2'h0, 13'h0123, 8'h00);
        cmp("copied back", 8'h5A, rsp_rdata);
        cmd(2'h0, 13'h1FFF, 8'h00);
        cmp("copied top", 8'hA5, rsp_rdata);
        $display("test nv done");
    endtask : t_nv
    task automatic t_abort();
        cmd(2'h0, 13'h0000, 8'h00);
        cmd(2'h0, 13'h1555, 8'h00);
        cmd(2'h0, 13'h0AAA, 8'h00);
        cmd(2'h1, 13'h0AAA, 8'h77);
        cmd(2'h0, 13'h1FFF, 8'h00);
        cmd(2'h0, 13'h10F0, 8'h00);
        cmd(2'h0, 13'h0F0F, 8'h00);
        cmp("write abort read", 8'h00, rsp_rdata);
        cmp("write abort saves", 8'h01, 8'(save_cnt));
        cmd(2'h0, 13'h0000, 8'h00);
        cmd(2'h0, 13'h1555, 8'h00);
        cmd(2'h0, 13'h0AAA, 8'h00);
        cmd(2'h0, 13'h1FFF, 8'h00);
        cmd(2'h0, 13'h0123, 8'h00);
        cmd(2'h0, 13'h10F0, 8'h00);
        cmd(2'h0, 13'h0F0E, 8'h00);
        cmp("read abort read", 8'h00, rsp_rdata);
        cmp("read abort copies", 8'h01, 8'(copy_cnt));
        $display("test abort done");
    endtask : t_abort
    task automatic summarize();
        $display("mismatches %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = 2'h0;
        cmd_addr = 13'h0000;
        cmd_wdata = 8'h00;
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        t_powerup();
        t_rw();
        t_nv();
        t_abort();
        summarize();
    end
endmodule : testbench

bind nvs_host_ctrl nvs_host_properties chk_u (
    .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rsp_valid(rsp_valid),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr_in(addr_in),
    .data_io_oe_n(data_io_oe_n));
